/* File: include/rcs_pkg.sv */
// Package for the radio command strobe controller: strobe codes, states, timing.
// Assumes a single 25 MHz clock domain; nothing here is synthesised on its own.
package rcs_pkg;
    // ----------------------------------------
    // Strobe codes
    // ----------------------------------------
    localparam logic [7:0] SYNTH_ON_STROBE = 8'h00;
    localparam logic [7:0] CALIBRATE_STROBE = 8'h01;
    localparam logic [7:0] RECEIVE_STROBE = 8'h02;
    localparam logic [7:0] TRANSMIT_STROBE = 8'h03;
    localparam logic [7:0] GO_IDLE_STROBE = 8'h04;
    localparam logic [7:0] FREQ_CORRECT_STROBE = 8'h05;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_HZ = 25_000_000;
    localparam int CAL_TIME_NS = 720;
    localparam int CAL_CYCLES = (CAL_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int AFC_TIME_NS = 200;
    localparam int AFC_CYCLES = (AFC_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int TIMER_W = 8;

    // ----------------------------------------
    // Decoded commands and states
    // ----------------------------------------
    typedef enum logic [2:0] {
        CMD_NOP, CMD_SYNTH_ON, CMD_CAL, CMD_RX, CMD_TX, CMD_IDLE, CMD_AFC
    } rcs_cmd_t;

    typedef enum logic [6:0] {
        ST_IDLE = 7'b000_0001,
        ST_CAL = 7'b000_0010,
        ST_SYNTH = 7'b000_0100,
        ST_RX = 7'b000_1000,
        ST_TX = 7'b001_0000,
        ST_AFC = 7'b010_0000,
        ST_CAL_OFF = 7'b100_0000
    } rcs_state_t;
endpackage

/* File: include/rcs_strobe_if.sv */
// Interface carrying a decoded strobe command between decoder and controller.
// Assumes both ends share i_clk.
`timescale 1ns/1ps
interface rcs_strobe_if;
    logic valid;
    rcs_pkg::rcs_cmd_t cmd;
    modport src (output valid, output cmd);
    modport dst (input valid, input cmd);
endinterface

/* File: rtl/rcs_radio_ctrl.sv */
// Radio top-level state control driven by CPU command strobes.
// Assumes the CPU writes the strobe register on i_clk (the radio reference clock);
// auto-calibration and clear-channel inputs come from the same domain.
`timescale 1ns/1ps
// Behaviour
// - Each CPU byte write to the strobe register is decoded as exactly one command.
// - Synthesizer, receive and transmit are enabled only by their strobe commands.
// - Code 0x00 turns the synthesizer on, calibrating first only from idle when auto-calibration is 1.
// - Code 0x00 during receive or transmit drops to a synthesizer-only wait state.
// - Code 0x01 calibrates the synthesizer and then turns it off.
// - Code 0x02 enters receive, calibrating first only from idle with auto-calibration 1.
// - Code 0x03 from idle enters transmit, calibrating first when auto-calibration is set.
// - Code 0x03 in receive with clear channel assessment on goes to transmit only if clear.
// - Code 0x04 abandons receive or transmit, turns the synthesizer off and goes idle.
// - Code 0x05 performs a frequency correction adjustment of the synthesizer.
// - All logic runs from the single crystal reference clock.
module rcs_radio_ctrl #(
    parameter int CAL_CYCLES = rcs_pkg::CAL_CYCLES,
    parameter int AFC_CYCLES = rcs_pkg::AFC_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_strobe_wr,
    input wire logic [7:0] i_radio_strobe_register,
    input wire logic i_auto_calibrate_flag,
    input wire logic i_cca_enable,
    input wire logic i_channel_clear,
    output logic o_synth_on,
    output logic o_rx_on,
    output logic o_tx_on,
    output logic o_calibrating,
    output logic o_afc_busy,
    output logic [6:0] o_state
);
    // ----------------------------------------
    // Strobe decode
    // ----------------------------------------
    rcs_strobe_if cmd_bus ();

    rcs_strobe_decode u_decode (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_wr(i_strobe_wr),
        .i_data(i_radio_strobe_register),
        .cmd_bus(cmd_bus)
    );

    // ----------------------------------------
    // Command helpers
    // ----------------------------------------
    // Calibrate first only on a cold start from idle with auto-calibration on;
    // from a running synthesizer it would only cost turnaround time.
    function automatic logic cal_first(input rcs_pkg::rcs_state_t s, input logic autocal);
        cal_first = (s == rcs_pkg::ST_IDLE) && autocal;
    endfunction

    // ----------------------------------------
    // State machine
    // ----------------------------------------
    localparam logic [rcs_pkg::TIMER_W-1:0] CAL_LAST = rcs_pkg::TIMER_W'(CAL_CYCLES - 1);
    localparam logic [rcs_pkg::TIMER_W-1:0] AFC_LAST = rcs_pkg::TIMER_W'(AFC_CYCLES - 1);

    rcs_pkg::rcs_state_t state;
    rcs_pkg::rcs_state_t next_state;
    rcs_pkg::rcs_state_t after_cal; // Where a calibration ends up
    rcs_pkg::rcs_state_t next_after_cal;
    rcs_pkg::rcs_state_t after_afc;
    rcs_pkg::rcs_state_t next_after_afc;
    // Counts cycles inside CAL, CAL_OFF and AFC; restarts on every state change.
    // Limitation: TIMER_W bounds CAL_CYCLES and AFC_CYCLES to 256.
    logic [rcs_pkg::TIMER_W-1:0] timer;
    logic [rcs_pkg::TIMER_W-1:0] next_timer;
    logic cmd_go;

    assign cmd_go = cmd_bus.valid;

    // Next state; commands during calibration or AFC are dropped, except go-idle, which aborts;
    // dropping them keeps the synthesizer from being retuned mid-sequence.
    always_comb begin
        next_state = state;
        next_after_cal = after_cal;
        next_after_afc = after_afc;
        next_timer = timer;
        unique case (state)
            rcs_pkg::ST_CAL, rcs_pkg::ST_CAL_OFF, rcs_pkg::ST_AFC: begin
                if (cmd_go && cmd_bus.cmd == rcs_pkg::CMD_IDLE) begin
                    next_state = rcs_pkg::ST_IDLE;
                end else if (state == rcs_pkg::ST_AFC) begin
                    if (timer == AFC_LAST) begin
                        next_state = after_afc;
                        next_timer = '0;
                    end else begin
                        next_timer = timer + 1'b1;
                    end
                end else if (timer == CAL_LAST) begin
                    next_timer = '0;
                    next_state = (state == rcs_pkg::ST_CAL_OFF) ?
                        rcs_pkg::ST_IDLE : after_cal;
                end else begin
                    next_timer = timer + 1'b1;
                end
            end
            default: begin
                if (cmd_go) begin
                    unique case (cmd_bus.cmd)
                        rcs_pkg::CMD_SYNTH_ON: begin
                            if (cal_first(state, i_auto_calibrate_flag)) begin
                                next_state = rcs_pkg::ST_CAL;
                                next_after_cal = rcs_pkg::ST_SYNTH;
                            end else begin
                                next_state = rcs_pkg::ST_SYNTH;
                            end
                        end
                        rcs_pkg::CMD_CAL: begin
                            next_state = rcs_pkg::ST_CAL_OFF;
                        end
                        rcs_pkg::CMD_RX: begin
                            if (cal_first(state, i_auto_calibrate_flag)) begin
                                next_state = rcs_pkg::ST_CAL;
                                next_after_cal = rcs_pkg::ST_RX;
                            end else begin
                                next_state = rcs_pkg::ST_RX;
                            end
                        end
                        rcs_pkg::CMD_TX: begin
                            if (cal_first(state, i_auto_calibrate_flag)) begin
                                next_state = rcs_pkg::ST_CAL;
                                next_after_cal = rcs_pkg::ST_TX;
                            end else if (state == rcs_pkg::ST_RX && i_cca_enable &&
                                         !i_channel_clear) begin
                                next_state = rcs_pkg::ST_RX; // Busy channel
                            end else begin
                                next_state = rcs_pkg::ST_TX;
                            end
                        end
                        rcs_pkg::CMD_IDLE: begin
                            next_state = rcs_pkg::ST_IDLE;
                        end
                        rcs_pkg::CMD_AFC: begin
                            next_state = rcs_pkg::ST_AFC;
                            next_after_afc = state;
                        end
                        default: begin
                            next_state = state; // No-op
                        end
                    endcase
                end
            end
        endcase
        if (next_state != state) begin
            next_timer = '0;
        end
    end

    // State registers; reset lands idle, synthesizer off
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state <= rcs_pkg::ST_IDLE;
            after_cal <= rcs_pkg::ST_SYNTH;
            after_afc <= rcs_pkg::ST_IDLE;
            timer <= '0;
        end else begin
            state <= next_state;
            after_cal <= next_after_cal;
            after_afc <= next_after_afc;
            timer <= next_timer;
        end
    end

    // ----------------------------------------
    // Outputs from flip-flops
    // ----------------------------------------
    // Flags decode next_state, so they line up with o_state cycle for cycle;
    // registering them keeps decode glitches off the outputs.
    logic synth_on;
    logic next_synth_on;
    logic rx_on;
    logic next_rx_on;
    logic tx_on;
    logic next_tx_on;
    logic calibrating;
    logic next_calibrating;
    logic afc_busy;
    logic next_afc_busy;

    // Synthesizer runs in every state except idle
    always_comb begin
        next_synth_on = (next_state != rcs_pkg::ST_IDLE);
        next_rx_on = (next_state == rcs_pkg::ST_RX);
        next_tx_on = (next_state == rcs_pkg::ST_TX);
        next_calibrating = (next_state == rcs_pkg::ST_CAL) ||
            (next_state == rcs_pkg::ST_CAL_OFF);
        next_afc_busy = (next_state == rcs_pkg::ST_AFC);
    end

    // Flag registers; reset values match the idle state
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            synth_on <= 1'b0;
            rx_on <= 1'b0;
            tx_on <= 1'b0;
            calibrating <= 1'b0;
            afc_busy <= 1'b0;
        end else begin
            synth_on <= next_synth_on;
            rx_on <= next_rx_on;
            tx_on <= next_tx_on;
            calibrating <= next_calibrating;
            afc_busy <= next_afc_busy;
        end
    end

    // Drive the pins
    assign o_synth_on = synth_on;
    assign o_rx_on = rx_on;
    assign o_tx_on = tx_on;
    assign o_calibrating = calibrating;
    assign o_afc_busy = afc_busy;
    assign o_state = state;
endmodule // rcs_radio_ctrl

/* File: rtl/rcs_strobe_decode.sv */
// Strobe byte decoder: turns one written byte into one command.
// Assumes the write strobe is a one-cycle pulse on the same clock.
`timescale 1ns/1ps
module rcs_strobe_decode (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_wr,
    input wire logic [7:0] i_data,
    rcs_strobe_if.src cmd_bus
);
    // ----------------------------------------
    // Byte to command
    // ----------------------------------------
    function automatic rcs_pkg::rcs_cmd_t decode(input logic [7:0] b);
        unique case (b)
            rcs_pkg::SYNTH_ON_STROBE: decode = rcs_pkg::CMD_SYNTH_ON;
            rcs_pkg::CALIBRATE_STROBE: decode = rcs_pkg::CMD_CAL;
            rcs_pkg::RECEIVE_STROBE: decode = rcs_pkg::CMD_RX;
            rcs_pkg::TRANSMIT_STROBE: decode = rcs_pkg::CMD_TX;
            rcs_pkg::GO_IDLE_STROBE: decode = rcs_pkg::CMD_IDLE;
            rcs_pkg::FREQ_CORRECT_STROBE: decode = rcs_pkg::CMD_AFC;
            default: decode = rcs_pkg::CMD_NOP; // Unknown byte is a no-op
        endcase
    endfunction

    logic valid;
    rcs_pkg::rcs_cmd_t cmd;
    logic next_valid;
    rcs_pkg::rcs_cmd_t next_cmd;

    // One write gives exactly one command
    always_comb begin
        next_valid = i_wr;
        next_cmd = i_wr ? decode(i_data) : rcs_pkg::CMD_NOP;
    end

    // Register the command
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            valid <= 1'b0;
            cmd <= rcs_pkg::CMD_NOP;
        end else begin
            valid <= next_valid;
            cmd <= next_cmd;
        end
    end

    assign cmd_bus.valid = valid;
    assign cmd_bus.cmd = cmd;
endmodule // rcs_strobe_decode

/* File: verification/rcs_cpu_model.sv */
// CPU side model: issues single-byte strobe writes.
// Assumes the radio samples the byte with the write pulse.
`timescale 1ns/1ps
module rcs_cpu_model (
    input wire logic i_clk,
    output logic o_wr,
    output logic [7:0] o_data
);
    // Bus quiet at start
    initial begin
        o_wr = 1'b0;
        o_data = 8'h00;
    end
    // One-cycle write; released data scrambles so stale bytes never look valid
    task automatic write(input logic [7:0] b, input int gap);
        @(posedge i_clk);
        o_wr <= 1'b1;
        o_data <= b;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_data <= ~b;
        repeat (gap) @(posedge i_clk);
    endtask
endmodule // rcs_cpu_model

/* File: verification/rcs_radio_ctrl_sva.sv */
// Checker for the radio strobe controller, watching its top-level ports.
// Assumes lone strobe writes with idle cycles around them.
`timescale 1ns/1ps
module rcs_radio_ctrl_sva #(
    parameter int CAL_CYCLES = 18,
    parameter int AFC_CYCLES = 5
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_strobe_wr,
    input wire logic [7:0] i_radio_strobe_register,
    input wire logic i_auto_calibrate_flag,
    input wire logic i_cca_enable,
    input wire logic i_channel_clear,
    input wire logic o_synth_on,
    input wire logic o_rx_on,
    input wire logic o_tx_on,
    input wire logic o_calibrating,
    input wire logic o_afc_busy,
    input wire logic [6:0] o_state
);
    // ----------------------------------------
    // Framing of one strobe write
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    localparam int CAL_MAX = CAL_CYCLES + 1;
    localparam int AFC_MAX = AFC_CYCLES + 1;
    logic [7:0] d;
    // Short alias for the written byte
    assign d = i_radio_strobe_register;
    // Lone write whose byte and context satisfy b
    sequence s_wr(b);
        !i_strobe_wr [*2] ##1 (i_strobe_wr && b) ##1 !i_strobe_wr;
    endsequence

    // ----------------------------------------
    // State transitions
    // ----------------------------------------
    property p_reset; $rose(i_arst_n) |-> o_state == 7'h01 && !o_synth_on; endproperty
    a_reset: assert property (p_reset) else $error("not idle after reset");
    property p_synth; s_wr(d == 8'h00 && o_state[0] && i_auto_calibrate_flag)
        |-> ##2 o_state[1] && o_calibrating && o_synth_on; endproperty
    a_synth: assert property (p_synth) else $error("no calibration on synth start");
    property p_turn; s_wr(d == 8'h00 && (o_state[3] || o_state[4]))
        |-> ##2 o_state == 7'h04 && !o_rx_on && !o_tx_on; endproperty
    a_turn: assert property (p_turn) else $error("no synth wait state");
    property p_caloff; s_wr(d == 8'h01 && o_state[0])
        |-> ##2 o_state[6] && o_calibrating ##[1:CAL_MAX] o_state[0]; endproperty
    a_caloff: assert property (p_caloff) else $error("calibrate and off failed");
    property p_rxcal; s_wr(d == 8'h02 && o_state[0] && i_auto_calibrate_flag)
        |-> ##2 o_state[1] ##[1:CAL_MAX] o_rx_on; endproperty
    a_rxcal: assert property (p_rxcal) else $error("receive after calibration failed");
    property p_cca; s_wr(d == 8'h03 && o_state[3] && i_cca_enable && !i_channel_clear)
        |-> ##2 o_state == 7'h08; endproperty
    a_cca: assert property (p_cca) else $error("transmit on busy channel");
    property p_idle; s_wr(d == 8'h04) |-> ##2 o_state == 7'h01 && !o_synth_on; endproperty
    a_idle: assert property (p_idle) else $error("idle strobe ignored");
    property p_afc; s_wr(d == 8'h05 && o_state[2])
        |-> ##2 o_afc_busy ##[1:AFC_MAX] o_state == 7'h04; endproperty
    a_afc: assert property (p_afc) else $error("correction step failed");
    property p_txcal; s_wr(d == 8'h03 && o_state[0] && i_auto_calibrate_flag)
        |-> ##2 o_state[1] ##[1:CAL_MAX] o_tx_on; endproperty
    a_txcal: assert property (p_txcal) else $error("no calibrated transmit");
    property p_nop; s_wr(d > 8'h05 && (o_state[0] || o_state[2] || o_state[3] || o_state[4]))
        |-> ##2 $stable(o_state); endproperty
    a_nop: assert property (p_nop) else $error("undefined strobe changed state");
endmodule // rcs_radio_ctrl_sva

bind rcs_radio_ctrl rcs_radio_ctrl_sva #(.CAL_CYCLES(CAL_CYCLES), .AFC_CYCLES(AFC_CYCLES))
    u_sva (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_strobe_wr(i_strobe_wr),
    .i_radio_strobe_register(i_radio_strobe_register),
    .i_auto_calibrate_flag(i_auto_calibrate_flag), .i_cca_enable(i_cca_enable),
    .i_channel_clear(i_channel_clear), .o_synth_on(o_synth_on), .o_rx_on(o_rx_on),
    .o_tx_on(o_tx_on), .o_calibrating(o_calibrating), .o_afc_busy(o_afc_busy),
    .o_state(o_state));

/* File: verification/tb_rcs_radio_ctrl.sv */
// Testbench for the radio strobe controller, strobes sent through a CPU model.
// Assumes package, interface and design are compiled first.
`timescale 1ns/1ps
module tb_rcs_radio_ctrl;
    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    localparam int CAL = 8;
    logic clk, arst_n, auto, cca, clr, synth, rx, tx, cal, afc;
    logic wr;
    logic [7:0] data;
    logic [6:0] st;
    int mismatches = 0;
    int compares = 0;
    logic [7:0] data_nop [3] = '{8'h06, 8'h80, 8'hFF};
    rcs_radio_ctrl #(.CAL_CYCLES(CAL), .AFC_CYCLES(3)) rcs_radio_ctrl_inst (.i_clk(clk),
        .i_arst_n(arst_n), .i_strobe_wr(wr), .i_radio_strobe_register(data),
        .i_auto_calibrate_flag(auto), .i_cca_enable(cca), .i_channel_clear(clr),
        .o_synth_on(synth), .o_rx_on(rx), .o_tx_on(tx), .o_calibrating(cal),
        .o_afc_busy(afc), .o_state(st));
    rcs_cpu_model rcs_cpu_model_inst (.i_clk(clk), .o_wr(wr), .o_data(data));
    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string n, input logic [6:0] e, input logic [6:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    // Expected flags follow from what each state means
    task automatic chk_outs(input logic [6:0] e);
        chk("outs", {2'h0, e != rcs_pkg::ST_IDLE, e == rcs_pkg::ST_RX, e == rcs_pkg::ST_TX,
            e == rcs_pkg::ST_CAL || e == rcs_pkg::ST_CAL_OFF, e == rcs_pkg::ST_AFC},
            {2'h0, synth, rx, tx, cal, afc});
    endtask
    // Write, then look two edges after the design takes it
    task automatic cmd(input logic [7:0] c, input logic [6:0] e);
        rcs_cpu_model_inst.write(c, 0);
        repeat (2) @(posedge clk);
        #1;
        chk("state", e, st);
        chk("synth", {6'h00, e != rcs_pkg::ST_IDLE}, {6'h00, synth});
        chk_outs(e);
    endtask
    // Bounded wait for a timed state to finish
    task automatic wait_st(input logic [6:0] e);
        for (int i = 0; i < CAL + 4 && st !== e; i++) begin
            @(posedge clk);
            #1;
        end
        chk("settle", e, st);
        chk_outs(e);
    endtask
    task automatic lv(input logic a, input logic c, input logic k);
        @(posedge clk);
        auto <= a;
        cca <= c;
        clr <= k;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_rx;
        lv(1, 0, 0);
        cmd(8'h02, rcs_pkg::ST_CAL);
        wait_st(rcs_pkg::ST_RX);
        cmd(8'h00, rcs_pkg::ST_SYNTH);
        cmd(8'h02, rcs_pkg::ST_RX);
        cmd(8'h04, rcs_pkg::ST_IDLE);
    endtask
    task automatic t_synth;
        cmd(8'h00, rcs_pkg::ST_CAL);
        wait_st(rcs_pkg::ST_SYNTH);
        cmd(8'h05, rcs_pkg::ST_AFC);
        wait_st(rcs_pkg::ST_SYNTH);
        cmd(8'h03, rcs_pkg::ST_TX);
        cmd(8'h00, rcs_pkg::ST_SYNTH);
        cmd(8'h04, rcs_pkg::ST_IDLE);
    endtask
    task automatic t_tx;
        cmd(8'h03, rcs_pkg::ST_CAL);
        wait_st(rcs_pkg::ST_TX);
        cmd(8'h04, rcs_pkg::ST_IDLE);
        lv(0, 1, 0);
        cmd(8'h03, rcs_pkg::ST_TX);
        cmd(8'h02, rcs_pkg::ST_RX);
        cmd(8'h03, rcs_pkg::ST_RX);
        lv(0, 1, 1);
        cmd(8'h03, rcs_pkg::ST_TX);
    endtask
    // Undefined bytes, abort in mid-calibration, reset in mid-run
    task automatic t_misc;
        cmd(8'h02, rcs_pkg::ST_RX);
        foreach (data_nop[i]) cmd(data_nop[i], rcs_pkg::ST_RX);
        cmd(8'h04, rcs_pkg::ST_IDLE);
        cmd(8'h01, rcs_pkg::ST_CAL_OFF);
        wait_st(rcs_pkg::ST_IDLE);
        lv(1, 0, 0);
        cmd(8'h02, rcs_pkg::ST_CAL);
        cmd(8'h04, rcs_pkg::ST_IDLE);
        cmd(8'h00, rcs_pkg::ST_CAL);
        @(posedge clk);
        arst_n <= 1'b0;
        @(posedge clk);
        #1;
        chk("reset", rcs_pkg::ST_IDLE, st);
        @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk("reset", rcs_pkg::ST_IDLE, st);
        chk_outs(rcs_pkg::ST_IDLE);
        cmd(8'h02, rcs_pkg::ST_CAL);
        wait_st(rcs_pkg::ST_RX);
    endtask

    // ----------------------------------------
    // Sequence, watchdog and verdict
    // ----------------------------------------
    task automatic end_sim;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Main run
    initial begin
        arst_n = 1'b0;
        auto = 1'b0;
        cca = 1'b0;
        clr = 1'b0;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk("reset", rcs_pkg::ST_IDLE, st);
        chk("outs", 7'h00, {2'h0, synth, rx, tx, cal, afc});
        t_rx();
        t_synth();
        t_tx();
        t_misc();
        end_sim();
    end
    // Run takes well under a thousand cycles
    initial begin
        repeat (3000) @(posedge clk);
        mismatches++;
        end_sim();
    end
endmodule // tb_rcs_radio_ctrl
